// file: rtl/t2f_pkg.sv
// constants for the timer2 flag and baud-select block
package t2f_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS  = 8'h00;
	localparam logic [7:0] IRQST_OFS = 8'h04;
	localparam logic [7:0] IRQMK_OFS = 8'h08;
	localparam int         AW        = 8;
	// control register field positions
	localparam int OVF_BIT  = 7;
	localparam int EXF_BIT  = 6;
	localparam int RXB_BIT  = 5;
	localparam int TXB_BIT  = 4;
	localparam int EXEN_BIT = 3;
	// interrupt status / mask field positions
	localparam int IRQ_OVF_BIT = 0;
	localparam int IRQ_EXF_BIT = 1;
	// values after reset
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] IRQ_RST  = 2'h0;
	localparam logic       PIN_RST  = 1'b1;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;
	localparam logic        PULSE_RST = 1'b0;
	// serial modes that take a timer overflow as bit clock
	localparam logic [1:0] SMODE_1 = 2'h1;
	localparam logic [1:0] SMODE_3 = 2'h3;
endpackage

// file: rtl/t2f_edge_if.sv
// carrier between the pin conditioner and the flag logic
`timescale 1ns/100ps
interface t2f_edge_if;
	logic level;	// filtered pin level
	logic fall;	// one-cycle pulse on a filtered falling edge
	modport src (output level, output fall);
	modport dst (input level, input fall);
endinterface

// file: rtl/t2f_pin_sync.sv
// three-stage synchroniser and falling-edge detector for the external pin
`timescale 1ns/100ps
module t2f_pin_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin,
	t2f_edge_if.src   edge_o
);
	logic [2:0] sync_r;
	logic [2:0] sync_nxt;
	logic       level_r;
	logic       level_nxt;
	logic       fall_r;
	logic       fall_nxt;

	////////////////////////////////////////////////////////////////////////////
	// a change counts only once stages two and three agree, which also
	// rejects a single-cycle glitch; stage one feeds stage two only
	always_comb
	begin
		sync_nxt  = {sync_r[1:0], pin};
		level_nxt = level_r;
		fall_nxt  = 1'b0;
		if (sync_r[1] == sync_r[2])
		begin
			level_nxt = sync_r[2];
			fall_nxt  = level_r & ~sync_r[2];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_r  <= {3{t2f_pkg::PIN_RST}};
			level_r <= t2f_pkg::PIN_RST;
			fall_r  <= t2f_pkg::PULSE_RST;
		end
		else
		begin
			sync_r  <= sync_nxt;
			level_r <= level_nxt;
			fall_r  <= fall_nxt;
		end
	end

	assign edge_o.level = level_r;
	assign edge_o.fall  = fall_r;
endmodule

// file: rtl/t2f_top.sv
// timer2 status flags, external trigger and serial baud clock select
//
// Summary of operation
// R01: rollover sets the timer2 overflow flag
// R02: no overflow flag while either baud select set
// R03: software clears overflow flag; hardware never does
// R04: enabled pin falling edge sets external flag
// R05: software clears external flag by writing zero
// R06: receive clock source select in modes 1, 3
// R07: transmit clock source select in modes 1, 3
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
module t2f_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timer2_rollover,
	input  wire logic        timer1_overflow,
	input  wire logic [1:0]  serial_mode,
	input  wire logic        timer2_external_pin,
	output logic             capture_reload_req,
	output logic             rx_baud_tick,
	output logic             tx_baud_tick,
	output logic             irq
);
	t2f_edge_if pin_if ();

	logic [7:0]  ctrl_r;
	logic [7:0]  ctrl_nxt;
	logic [1:0]  irq_sts_r;
	logic [1:0]  irq_sts_nxt;
	logic [1:0]  irq_msk_r;
	logic [1:0]  irq_msk_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic        cap_r;
	logic        cap_nxt;
	logic        rxt_r;
	logic        rxt_nxt;
	logic        txt_r;
	logic        txt_nxt;
	logic        irq_r;
	logic        irq_nxt;
	logic        wr_en;
	logic        rd_setup;
	logic        hit_ctrl;
	logic        hit_sts;
	logic        hit_msk;
	logic        mapped;
	logic        ovf_set;
	logic        exf_set;
	logic        baud_mode;

	////////////////////////////////////////////////////////////////////////////
	// external pin conditioning; the pin is asynchronous to pclk, so the
	// conditioner costs about four cycles and drops a low pulse shorter
	// than two cycles
	t2f_pin_sync u_pin (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (timer2_external_pin),
		.edge_o  (pin_if)
	);

	////////////////////////////////////////////////////////////////////////////
	// apb decode: zero wait states, unmapped addresses answer with an error
	assign hit_ctrl = (paddr == t2f_pkg::CTRL_OFS);
	assign hit_sts  = (paddr == t2f_pkg::IRQST_OFS);
	assign hit_msk  = (paddr == t2f_pkg::IRQMK_OFS);
	assign mapped   = hit_ctrl | hit_sts | hit_msk;
	assign wr_en    = psel & penable & pwrite & mapped;
	assign rd_setup = psel & ~penable & ~pwrite;
	// pready tied high: every access phase lasts exactly one cycle
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~mapped;

	// flag set conditions; the pin edge only counts while the trigger is enabled
	assign ovf_set = timer2_rollover & ~ctrl_r[t2f_pkg::RXB_BIT]
		& ~ctrl_r[t2f_pkg::TXB_BIT];	// R01 R02
	assign exf_set = pin_if.fall & ctrl_r[t2f_pkg::EXEN_BIT];	// R04
	assign baud_mode = (serial_mode == t2f_pkg::SMODE_1) | (serial_mode == t2f_pkg::SMODE_3);

	////////////////////////////////////////////////////////////////////////////
	// register file next state; a hardware set in the clearing cycle wins
	// so an overflow that lands on the software write is never lost
	always_comb
	begin
		ctrl_nxt    = ctrl_r;
		irq_sts_nxt = irq_sts_r;
		irq_msk_nxt = irq_msk_r;
		if (wr_en && hit_ctrl)
		begin
			// flags accept only a zero; writing one leaves them as they are
			ctrl_nxt[t2f_pkg::OVF_BIT] = ctrl_r[t2f_pkg::OVF_BIT]
				& pwdata[t2f_pkg::OVF_BIT];	// R03
			ctrl_nxt[t2f_pkg::EXF_BIT] = ctrl_r[t2f_pkg::EXF_BIT]
				& pwdata[t2f_pkg::EXF_BIT];	// R05
			ctrl_nxt[t2f_pkg::RXB_BIT]  = pwdata[t2f_pkg::RXB_BIT];
			ctrl_nxt[t2f_pkg::TXB_BIT]  = pwdata[t2f_pkg::TXB_BIT];
			ctrl_nxt[t2f_pkg::EXEN_BIT] = pwdata[t2f_pkg::EXEN_BIT];
		end
		if (wr_en && hit_sts)
		begin
			// a written one clears the status bit, a zero leaves it
			irq_sts_nxt = irq_sts_r & ~pwdata[1:0];
		end
		if (wr_en && hit_msk)
		begin
			// a one lets the matching status bit reach irq
			irq_msk_nxt = pwdata[1:0];
		end
		if (ovf_set)
		begin
			ctrl_nxt[t2f_pkg::OVF_BIT]        = 1'b1;	// R01
			irq_sts_nxt[t2f_pkg::IRQ_OVF_BIT] = 1'b1;
		end
		if (exf_set)
		begin
			ctrl_nxt[t2f_pkg::EXF_BIT]        = 1'b1;	// R04
			irq_sts_nxt[t2f_pkg::IRQ_EXF_BIT] = 1'b1;
		end
		// unused low bits stay zero
		ctrl_nxt[2:0] = 3'h0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r    <= t2f_pkg::CTRL_RST;
			irq_sts_r <= t2f_pkg::IRQ_RST;
			irq_msk_r <= t2f_pkg::IRQ_RST;
		end
		else
		begin
			ctrl_r    <= ctrl_nxt;
			irq_sts_r <= irq_sts_nxt;
			irq_msk_r <= irq_msk_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data is captured in the setup cycle and held through access
	// limitation: a flag set during the access cycle shows on the next read
	always_comb
	begin
		rdata_nxt = rdata_r;
		if (rd_setup)
		begin
			rdata_nxt = 32'h0000_0000;
			if (hit_ctrl)
			begin
				rdata_nxt = {24'h00_0000, ctrl_r};
			end
			else if (hit_sts)
			begin
				rdata_nxt = {30'h0000_0000, irq_sts_r};
			end
			else if (hit_msk)
			begin
				rdata_nxt = {30'h0000_0000, irq_msk_r};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata_r <= t2f_pkg::RDATA_RST;
		end
		else
		begin
			rdata_r <= rdata_nxt;
		end
	end

	assign prdata = rdata_r;

	////////////////////////////////////////////////////////////////////////////
	// outputs to timer core and serial port; outside modes 1 and 3 the
	// serial port makes its own bit clock, so both ticks stay low
	always_comb
	begin
		cap_nxt = exf_set;	// R04
		rxt_nxt = baud_mode & (ctrl_r[t2f_pkg::RXB_BIT] ? timer2_rollover
			: timer1_overflow);	// R06
		txt_nxt = baud_mode & (ctrl_r[t2f_pkg::TXB_BIT] ? timer2_rollover
			: timer1_overflow);	// R07
		// registered so the line cannot glitch while a status bit and its
		// mask bit change in the same cycle
		irq_nxt = |(irq_sts_r & irq_msk_r);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cap_r <= t2f_pkg::PULSE_RST;
			rxt_r <= t2f_pkg::PULSE_RST;
			txt_r <= t2f_pkg::PULSE_RST;
			irq_r <= t2f_pkg::PULSE_RST;
		end
		else
		begin
			cap_r <= cap_nxt;
			rxt_r <= rxt_nxt;
			txt_r <= txt_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign capture_reload_req = cap_r;
	assign rx_baud_tick       = rxt_r;
	assign tx_baud_tick       = txt_r;
	assign irq                = irq_r;
endmodule

// file: dv/t2f_checker.sv
// port assertions for the timer2 flag block
`timescale 1ns/100ps
module t2f_checker (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       timer2_rollover,
	input wire logic       timer1_overflow,
	input wire logic [1:0] serial_mode,
	input wire logic       timer2_external_pin,
	input wire logic       capture_reload_req,
	input wire logic       rx_baud_tick,
	input wire logic       tx_baud_tick
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a timer overflow one cycle back, in mode 1 or 3
	sequence src_cause;
		$past(timer2_rollover || timer1_overflow) && $past(serial_mode[0]);
	endsequence
	chk_rx_cause: assert property (rx_baud_tick |-> src_cause)
		else $error("rx tick without cause");
	chk_tx_cause: assert property (tx_baud_tick |-> src_cause)
		else $error("tx tick without cause");
	chk_mode_off: assert property (!serial_mode[0] |=> !rx_baud_tick && !tx_baud_tick)
		else $error("tick outside modes 1 and 3");
	chk_req_pulse: assert property (capture_reload_req |=> !capture_reload_req)
		else $error("capture request too long");
	// the two pin samples that made the filtered level agree low lie four and
	// five cycles before the request; later samples may already be high again
	sequence pin_was_low;
		!$past(timer2_external_pin, 4) && !$past(timer2_external_pin, 5);
	endsequence
	chk_req_pin: assert property (capture_reload_req |-> pin_was_low)
		else $error("capture request without pin low");
endmodule

// file: dv/t2f_serial_model.sv
// serial port bit-clock consumer that counts the ticks it gets
`timescale 1ns/100ps
module t2f_serial_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        rx_tick,
	input  wire logic        tx_tick,
	output logic      [31:0] rx_cnt,
	output logic      [31:0] tx_cnt
);
	// a lost or extra tick shifts the count for good
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_cnt <= 32'h0;
			tx_cnt <= 32'h0;
		end
		else
		begin
			rx_cnt <= rx_cnt + 32'(rx_tick);
			tx_cnt <= tx_cnt + 32'(tx_tick);
		end
	end
endmodule

// file: dv/t2f_top_tb.sv
// self-checking bench for the timer2 flag block
`timescale 1ns/100ps
module t2f_top_tb;
	logic        pclk, rstn, psel, pen, pwr, t2r, t1o, pin, rdy, err, req, rxt, txt, irq, er;
	logic [1:0]  smode;
	logic [7:0]  addr;
	logic [31:0] wd, prd, rd, rxc, txc;
	int          err_total, n_checks, erx, etx;
	int          n_req = 0;
	t2f_top u_t2f_top (.pclk(pclk), .presetn(rstn), .psel(psel), .penable(pen), .pwrite(pwr),
		.paddr(addr), .pwdata(wd), .prdata(prd), .pready(rdy), .pslverr(err),
		.timer2_rollover(t2r), .timer1_overflow(t1o), .serial_mode(smode),
		.timer2_external_pin(pin), .capture_reload_req(req), .rx_baud_tick(rxt),
		.tx_baud_tick(txt), .irq(irq));
	t2f_serial_model u_t2f_serial_model (.pclk(pclk), .presetn(rstn), .rx_tick(rxt),
		.tx_tick(txt), .rx_cnt(rxc), .tx_cnt(txc));
	// capture requests seen by the timer core; a lost or doubled pulse shows here
	always @(posedge pclk)
	begin
		if (req === 1'b1)
			n_req <= n_req + 1;
	end
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// apb master: request held until pready is seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwr  <= w;
		addr <= a;
		wd   <= d;
		@(posedge pclk);
		pen <= 1'b1;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (rdy !== 1'b1 && i < 16);
		rd = prd;
		er = err;
		psel <= 1'b0;
		pen  <= 1'b0;
		// a wait that runs out ends the run here, after the bus is released
		if (rdy !== 1'b1)
		begin
			err_total++;
			end_of_test();
		end
	endtask
	// one-cycle overflow pulses, then time for the tick to be counted
	task automatic pulse(input logic a, input logic b);
		@(posedge pclk);
		t2r <= a;
		t1o <= b;
		@(posedge pclk);
		t2r <= 1'b0;
		t1o <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	initial
	begin
		{rstn, psel, pen, pwr, t2r, t1o, smode, addr, wd} = '0;
		pin = 1'b1;
		err_total = 0;
		n_checks = 0;
		erx = 0;
		etx = 0;
		repeat (3) @(posedge pclk);
		rstn <= 1'b1;
		xfer(1'b0, 8'h0c, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		xfer(1'b1, 8'h08, 32'h1);
		pulse(1'b1, 1'b0);
		xfer(1'b1, 8'h00, 32'h80);
		xfer(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h80);
		chk(irq, 1'b1);
		// every mode against every source choice
		for (int k = 0; k < 16; k++)
		begin
			smode <= k[3:2];
			xfer(1'b1, 8'h00, {26'h0, k[1:0], 4'h0});
			xfer(1'b1, 8'h04, 32'h3);
			pulse(1'b1, 1'b0);
			erx += k[2] & k[1];
			etx += k[2] & k[0];
			chk(rxc, erx);
			chk(txc, etx);
			xfer(1'b0, 8'h00, 32'h0);
			chk(rd[7], k[1:0] == 2'h0);
			chk(irq, k[1:0] == 2'h0);
			pulse(1'b0, 1'b1);
			erx += k[2] & !k[1];
			etx += k[2] & !k[0];
			chk(rxc, erx);
			chk(txc, etx);
		end
		// pin edge with trigger on, then off; the ext event stays masked
		xfer(1'b1, 8'h00, 32'h08);
		pin <= 1'b0;
		repeat (10) @(posedge pclk);
		xfer(1'b1, 8'h00, 32'h48);
		xfer(1'b0, 8'h00, 32'h0);
		chk(rd[6], 1'b1);
		chk(irq, 1'b0);
		chk(n_req, 32'h1);
		xfer(1'b1, 8'h00, 32'h0);
		pin <= 1'b1;
		repeat (10) @(posedge pclk);
		pin <= 1'b0;
		repeat (10) @(posedge pclk);
		xfer(1'b0, 8'h00, 32'h0);
		chk(rd[6], 1'b0);
		chk(n_req, 32'h1);
		end_of_test();
	end
endmodule
////////////////////////////////////////
bind t2f_top t2f_checker u_t2f_checker (.pclk(pclk), .presetn(presetn),
	.timer2_rollover(timer2_rollover), .timer1_overflow(timer1_overflow),
	.serial_mode(serial_mode), .timer2_external_pin(timer2_external_pin),
	.capture_reload_req(capture_reload_req), .rx_baud_tick(rx_baud_tick),
	.tx_baud_tick(tx_baud_tick));
